// [dv/core_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------
// Core side: takes offers, signals end of handler
// ----------------------------------------------------------
module core_model
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       irq_req,
    input  wire logic [7:0] irq_vector,
    input  wire logic [1:0] irq_level,
    input  wire logic [1:0] ack_delay,
    input  wire logic       ret_cmd,
    output logic            irq_ack,
    output logic            irq_return,
    output logic      [7:0] took_cnt,
    output logic      [7:0] took_vector,
    output logic      [1:0] took_level
);
    logic [1:0] wait_cnt;

    always_ff @(posedge sys_clk)
    begin
        irq_ack    <= 1'b0;
        irq_return <= ret_cmd & ~rst;
        if (rst)
        begin
            wait_cnt <= 2'h0;
            took_cnt <= 8'h00;
        end
        else if (irq_ack)
        begin
            took_cnt    <= took_cnt + 8'h01;
            took_vector <= irq_vector;
            took_level  <= irq_level;
            wait_cnt    <= 2'h0;
        end
        else if (irq_req)
        begin
            // A slow core lets the offer stand, so it may be replaced
            if (wait_cnt >= ack_delay)
                irq_ack <= 1'b1;
            else
                wait_cnt <= wait_cnt + 2'h1;
        end
        else
            wait_cnt <= 2'h0;
    end
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sfr_wr = 1'b0;
    logic       ext0_pin_n = 1'b1;
    logic       ext1_pin_n = 1'b1;
    logic       ext0_edge_mode = 1'b1;
    logic       ext1_edge_mode = 1'b0;
    logic       timer0_overflow_flag = 1'b0;
    logic       timer1_overflow_flag = 1'b0;
    logic       serial_rx_done_flag = 1'b0;
    logic       serial_tx_done_flag = 1'b0;
    logic       timer2_overflow_flag = 1'b0;
    logic       timer2_ext_trigger_flag = 1'b0;
    logic [1:0] ack_delay = 2'h0;
    logic       ret_cmd = 1'b0;
    logic [7:0] sfr_rdata, irq_vector, took_cnt, took_vector, base;
    logic [1:0] irq_level, took_level;
    logic [3:0] in_service_level;
    logic       irq_ack, irq_return, irq_req;
    logic       ext0_request_flag, ext1_request_flag;
    logic       timer0_flag_clear, timer1_flag_clear;
    int         miscompares = 0;
    int         num_checks = 0;

    always #4 sys_clk = ~sys_clk;

    four_level_interrupt_prioritizer u_four_level_interrupt_prioritizer
    (
        .sys_clk, .rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rdata,
        .ext0_pin_n, .ext1_pin_n, .ext0_edge_mode, .ext1_edge_mode,
        .timer0_overflow_flag, .timer1_overflow_flag,
        .serial_rx_done_flag, .serial_tx_done_flag,
        .timer2_overflow_flag, .timer2_ext_trigger_flag,
        .irq_ack, .irq_return, .irq_req, .irq_vector, .irq_level,
        .ext0_request_flag, .ext1_request_flag, .timer0_flag_clear,
        .timer1_flag_clear, .in_service_level
    );

    core_model u_core_model
    (
        .sys_clk, .rst, .irq_req, .irq_vector, .irq_level, .ack_delay,
        .ret_cmd, .irq_ack, .irq_return, .took_cnt, .took_vector,
        .took_level
    );

    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge sys_clk);
        sfr_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr <= a;
        repeat (2) @(posedge sys_clk);
        chk("register", exp, sfr_rdata);
    endtask

    task automatic put(input logic [5:0] p, input logic [1:0] alt);
        ext1_pin_n              <= ~p[2];
        timer0_overflow_flag    <= p[1];
        timer1_overflow_flag    <= p[3];
        serial_rx_done_flag     <= p[4] & alt[0];
        serial_tx_done_flag     <= p[4] & ~alt[0];
        timer2_overflow_flag    <= p[5] & alt[1];
        timer2_ext_trigger_flag <= p[5] & ~alt[1];
    endtask

    task automatic wait_took();
        int n;
        n = 0;
        while (took_cnt === base && n < 40)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk("offer taken", 8'h01, {7'h0, took_cnt !== base});
    endtask

    // Pins need three edges to clear their flag before the return
    task automatic ret();
        repeat (4) @(posedge sys_clk);
        ret_cmd <= 1'b1;
        @(posedge sys_clk);
        ret_cmd <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic quiet();
        logic seen;
        seen = 1'b0;
        repeat (8)
        begin
            @(posedge sys_clk);
            seen = seen | irq_req;
        end
        chk("no offer", 8'h00, {7'h0, seen});
    endtask

    // Winner: highest level, lowest rank on a tie; {level, source}
    function automatic logic [4:0] pick(input logic [5:0] a, h, l);
        logic [4:0] b;
        logic       f;
        b = 5'h00;
        f = 1'b0;
        for (int i = 0; i < 6; i++)
            if (a[i] && (!f || {h[i], l[i]} > b[4:3]))
            begin
                b = {h[i], l[i], 3'(i)};
                f = 1'b1;
            end
        return b;
    endfunction

    // ----------------------------------------------------------
    // Tests
    // ----------------------------------------------------------
    initial
    begin
        logic [2:0][7:0] adr;
        logic [2:0][7:0] msk;
        int              idx[4];
        logic [31:0]     r;
        logic [7:0]      en;
        logic [5:0]      pend, act;
        logic [4:0]      w;
        adr = {four_level_irq_pkg::ADDR_SOURCE_ENABLE,
               four_level_irq_pkg::ADDR_PRIORITY_LOW,
               four_level_irq_pkg::ADDR_PRIORITY_HIGH};
        msk = {8'hbf, 8'h3f, 8'h3f};
        idx = '{1, 3, 4, 5};
        void'($urandom(89415));
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            rd(adr[i], 8'h00);
            wr(adr[i], 8'hff);
            rd(adr[i], msk[i]);
        end
        wr(8'h99, 8'h00);
        rd(8'h99, 8'h00);
        rd(adr[0], 8'h3f);
        $display("test registers done");
        wr(adr[1], 8'h28);
        wr(adr[0], 8'h30);
        for (int k = 0; k < 4; k++)
        begin
            base = took_cnt;
            put(6'(1 << idx[k]), 2'(k));
            wait_took();
            chk("vector", 8'(idx[k] * 8 + 3), took_vector);
            chk("level", 8'(k), {6'h0, took_level});
            chk("nest", 8'((1 << (k + 1)) - 1), {4'h0, in_service_level});
        end
        put(6'h02, 2'h0);
        quiet();
        for (int k = 3; k > 0; k--)
        begin
            ret();
            chk("resume", 8'((1 << k) - 1), {4'h0, in_service_level});
        end
        base = took_cnt;
        ret();
        wait_took();
        chk("vector", 8'h0b, took_vector);
        put(6'h00, 2'h0);
        ret();
        $display("test nesting done");
        wr(adr[1], 8'h00);
        wr(adr[0], 8'h00);
        base = took_cnt;
        ext0_pin_n <= 1'b0;
        wait_took();
        chk("vector", 8'h03, took_vector);
        chk("edge flag", 8'h00, {7'h0, ext0_request_flag});
        ext0_pin_n <= 1'b1;
        ret();
        base = took_cnt;
        put(6'h04, 2'h0);
        wait_took();
        chk("vector", 8'h13, took_vector);
        chk("level flag", 8'h01, {7'h0, ext1_request_flag});
        put(6'h00, 2'h0);
        ret();
        $display("test external done");
        for (int n = 0; n < 60; n++)
        begin
            r = $urandom;
            en = r[7:0] & 8'hbe;
            pend = r[25:20] & 6'h3e;
            wr(adr[2], en);
            wr(adr[0], {2'h0, r[13:8]});
            wr(adr[1], {2'h0, r[19:14]});
            ack_delay <= r[27:26];
            act = en[7] ? pend & en[5:0] : 6'h00;
            w = pick(act, r[13:8], r[19:14]);
            base = took_cnt;
            ext1_pin_n <= ~pend[2];
            repeat (3) @(posedge sys_clk);
            put(pend, r[29:28]);
            if (act == 6'h00)
                quiet();
            else
            begin
                wait_took();
                chk("vector", {2'h0, w[2:0], 3'h3}, took_vector);
                chk("level", {6'h0, w[4:3]}, {6'h0, took_level});
                chk("t0 clear", {7'h0, w[2:0] == 3'h1},
                    {7'h0, timer0_flag_clear});
                chk("t1 clear", {7'h0, w[2:0] == 3'h3},
                    {7'h0, timer1_flag_clear});
                chk("taken", 8'(4'h1 << w[4:3]), {4'h0, in_service_level});
            end
            put(6'h00, 2'h0);
            ret();
            chk("idle", 8'h00, {4'h0, in_service_level});
        end
        $display("test random done");
        stop_test();
    end

    // About 1500 cycles are expected; the 50000-cycle limit allows over thirty times that
    initial
    begin
        #400000;
        miscompares++;
        stop_test();
    end
endmodule
`default_nettype wire

// [rtl/four_level_interrupt_prioritizer.sv]
// Functional notes
// - Six request sources arbitrated, each given one of four levels.
// - Level is high-select bit over low-select bit; 11 is highest.
// - High-select register sits at address b7, same bit order.
// - Enabled request is taken when no same or higher level runs.
// - Same or higher level in service holds the request until it ends.
// - Higher level preempts a lower running handler; nesting four deep.
// - On return the interrupted lower handler resumes; one bit per level.
// - Ties go by fixed rank ext0..timer2; vectors 03 to 2b.
// - Vectoring clears timer0/1 flags and edge-mode external flags only.
// - Serial requests on rx or tx done; timer2 on overflow or trigger.
// - Level-mode external request follows the pin, never cleared.
// - Each source has an enable bit; disabled requests are not taken.
// - Priority bit one raises, zero lowers; top two bits unimplemented.
`timescale 1ns/1ps
`default_nettype none

module four_level_interrupt_prioritizer
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    output logic      [7:0] sfr_rdata,
    input  wire logic       ext0_pin_n,
    input  wire logic       ext1_pin_n,
    input  wire logic       ext0_edge_mode,
    input  wire logic       ext1_edge_mode,
    input  wire logic       timer0_overflow_flag,
    input  wire logic       timer1_overflow_flag,
    input  wire logic       serial_rx_done_flag,
    input  wire logic       serial_tx_done_flag,
    input  wire logic       timer2_overflow_flag,
    input  wire logic       timer2_ext_trigger_flag,
    input  wire logic       irq_ack,
    input  wire logic       irq_return,
    output logic            irq_req,
    output logic      [7:0] irq_vector,
    output logic      [1:0] irq_level,
    output logic            ext0_request_flag,
    output logic            ext1_request_flag,
    output logic            timer0_flag_clear,
    output logic            timer1_flag_clear,
    output logic      [3:0] in_service_level
);

    four_level_irq_pkg::arb_regs_type r;
    four_level_irq_pkg::arb_regs_type next_r;

    logic [7:0] source_enable_reg;
    logic [7:0] priority_low_select;
    logic [7:0] priority_high_select;
    logic [5:0] raw_request;
    logic [5:0] pending;
    logic       win_found;
    logic [2:0] win_src;
    logic [1:0] win_level;
    logic       blocked;
    logic       eligible;
    logic [3:0] top_onehot;
    logic [1:0] edge_mode;
    logic       taking;

    // ------------------------------------------------------------
    // Register file and ranking
    // ------------------------------------------------------------
    priority_register_file u_regs
    (
        .sys_clk              (sys_clk),
        .rst                  (rst),
        .sfr_addr             (sfr_addr),
        .sfr_wdata            (sfr_wdata),
        .sfr_wr               (sfr_wr),
        .sfr_rdata            (sfr_rdata),
        .source_enable_reg    (source_enable_reg),
        .priority_low_select  (priority_low_select),
        .priority_high_select (priority_high_select)
    );

    // ------------------------------------------------------------
    // Request vector, in polling rank order
    // ------------------------------------------------------------
    assign raw_request[0] = r.ext_flag[0];
    assign raw_request[1] = timer0_overflow_flag;
    assign raw_request[2] = r.ext_flag[1];
    assign raw_request[3] = timer1_overflow_flag;
    assign raw_request[4] = serial_rx_done_flag | serial_tx_done_flag;
    assign raw_request[5] = timer2_overflow_flag
                          | timer2_ext_trigger_flag;

    // Global enable gates every source on top of its own bit
    assign pending = raw_request & source_enable_reg[5:0]
                   & {6{source_enable_reg[four_level_irq_pkg::GLOBAL_ENABLE_BIT]}};

    request_ranker u_rank
    (
        .pending   (pending),
        .high_bits (priority_high_select[5:0]),
        .low_bits  (priority_low_select[5:0]),
        .found     (win_found),
        .source    (win_src),
        .level     (win_level)
    );

    // Any handler at the winner's level or above blocks it
    assign blocked  = |(r.in_service >> win_level);
    assign eligible = win_found && !blocked;
    assign taking   = (r.state == four_level_irq_pkg::ST_OFFER) && irq_ack;
    assign edge_mode = {ext1_edge_mode, ext0_edge_mode};

    // Highest in-service bit, the one a return releases
    always_comb
    begin
        top_onehot = 4'h0;
        for (int lv = 0; lv < four_level_irq_pkg::NUM_LEVELS; lv++)
        begin
            if (r.in_service[lv])
            begin
                top_onehot = 4'h1 << lv;
            end
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_r          = r;
        next_r.t0_clear = 1'b0;
        next_r.t1_clear = 1'b0;

        // External pins: two flops, then edge detection on the second
        next_r.ext_sync1 = {ext1_pin_n, ext0_pin_n};
        next_r.ext_sync2 = r.ext_sync1;
        next_r.ext_prev  = r.ext_sync2;
        for (int e = 0; e < 2; e++)
        begin
            if (edge_mode[e])
            begin
                // A new falling edge in the clearing cycle is kept
                if (taking && r.offer_src == 3'(2 * e))
                begin
                    next_r.ext_flag[e] = 1'b0;
                end
                if (r.ext_prev[e] && !r.ext_sync2[e])
                begin
                    next_r.ext_flag[e] = 1'b1;
                end
            end
            else
            begin
                next_r.ext_flag[e] = !r.ext_sync2[e];
            end
        end

        // Return releases first, so a same-cycle take still lands
        if (irq_return)
        begin
            next_r.in_service = r.in_service & ~top_onehot;
        end

        case (r.state)
            four_level_irq_pkg::ST_POLL:
            begin
                if (eligible)
                begin
                    next_r.state       = four_level_irq_pkg::ST_OFFER;
                    next_r.offer_src   = win_src;
                    next_r.offer_level = win_level;
                    next_r.vector      = four_level_irq_pkg::VECTORS[win_src];
                end
            end
            four_level_irq_pkg::ST_OFFER:
            begin
                if (irq_ack)
                begin
                    next_r.state = four_level_irq_pkg::ST_SETTLE;
                    next_r.in_service[r.offer_level] = 1'b1;
                    next_r.t0_clear =
                        (r.offer_src == four_level_irq_pkg::SRC_TIMER0);
                    next_r.t1_clear =
                        (r.offer_src == four_level_irq_pkg::SRC_TIMER1);
                end
                else if (eligible)
                begin
                    // Re-offer so a later, higher request is not hidden
                    next_r.offer_src   = win_src;
                    next_r.offer_level = win_level;
                    next_r.vector      = four_level_irq_pkg::VECTORS[win_src];
                end
                else
                begin
                    next_r.state = four_level_irq_pkg::ST_POLL;
                end
            end
            four_level_irq_pkg::ST_SETTLE:
            begin
                // Lets flag clears reach the sources before the next poll
                next_r.state = four_level_irq_pkg::ST_POLL;
            end
            default:
            begin
                next_r.state = four_level_irq_pkg::ST_POLL;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            r <= four_level_irq_pkg::ARB_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign irq_req           = (r.state == four_level_irq_pkg::ST_OFFER);
    assign irq_vector        = r.vector;
    assign irq_level         = r.offer_level;
    assign ext0_request_flag = r.ext_flag[0];
    assign ext1_request_flag = r.ext_flag[1];
    assign timer0_flag_clear = r.t0_clear;
    assign timer1_flag_clear = r.t1_clear;
    assign in_service_level  = r.in_service;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_take_when_free;
        @(posedge sys_clk) disable iff (rst)
        (r.state == four_level_irq_pkg::ST_POLL) && win_found
            && (r.in_service == 4'h0) && !irq_return |=> irq_req;
    endproperty
    a_take_when_free: assert property (p_take_when_free)
        else $error("free request not offered");

    property p_held_off;
        @(posedge sys_clk) disable iff (rst)
        irq_req |-> ((r.in_service >> irq_level) == 4'h0);
    endproperty
    a_held_off: assert property (p_held_off)
        else $error("offer at or below a level in service");

    property p_nest;
        @(posedge sys_clk) disable iff (rst)
        irq_req && irq_ack |=> in_service_level[$past(irq_level)]
            ##1 (r.state == four_level_irq_pkg::ST_POLL);
    endproperty
    a_nest: assert property (p_nest)
        else $error("taken level not marked in service");

    property p_resume;
        @(posedge sys_clk) disable iff (rst)
        irq_return && !taking |=>
            in_service_level == ($past(r.in_service) & ~$past(top_onehot));
    endproperty
    a_resume: assert property (p_resume)
        else $error("return did not release the top level");

    property p_vector;
        @(posedge sys_clk) disable iff (rst)
        irq_req |-> irq_vector == four_level_irq_pkg::VECTORS[r.offer_src];
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector does not match offered source");

    property p_timer_clear;
        @(posedge sys_clk) disable iff (rst)
        taking && (r.offer_src == four_level_irq_pkg::SRC_TIMER0)
            |=> timer0_flag_clear && !timer1_flag_clear ##1 !timer0_flag_clear;
    endproperty
    a_timer_clear: assert property (p_timer_clear)
        else $error("timer0 clear pulse wrong");

    property p_level_follow;
        @(posedge sys_clk) disable iff (rst)
        !ext1_edge_mode ##1 !ext1_edge_mode
            |-> ext1_request_flag == !$past(r.ext_sync2[1]);
    endproperty
    a_level_follow: assert property (p_level_follow)
        else $error("level-mode request does not follow pin");

    property p_enabled;
        @(posedge sys_clk) disable iff (rst)
        (r.state == four_level_irq_pkg::ST_POLL) ##1 irq_req
            |-> $past(pending[win_src]);
    endproperty
    a_enabled: assert property (p_enabled)
        else $error("disabled request offered");

    property p_level_bits;
        @(posedge sys_clk) disable iff (rst)
        (r.state == four_level_irq_pkg::ST_POLL) ##1 irq_req
            |-> irq_level == {$past(priority_high_select[win_src]),
                              $past(priority_low_select[win_src])};
    endproperty
    a_level_bits: assert property (p_level_bits)
        else $error("offered level does not match priority bits");

    property p_unimplemented;
        @(posedge sys_clk) disable iff (rst)
        (sfr_addr == four_level_irq_pkg::ADDR_PRIORITY_HIGH)
            |=> sfr_rdata[7:6] == 2'h0;
    endproperty
    a_unimplemented: assert property (p_unimplemented)
        else $error("unimplemented priority bits read nonzero");

endmodule

`default_nettype wire

// [rtl/four_level_irq_pkg.sv]
package four_level_irq_pkg;

    // ------------------------------------------------------------
    // Special function register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SOURCE_ENABLE = 8'ha8;
    localparam logic [7:0] ADDR_PRIORITY_LOW  = 8'hb8;
    localparam logic [7:0] ADDR_PRIORITY_HIGH = 8'hb7;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int         GLOBAL_ENABLE_BIT  = 7;
    localparam logic [7:0] ENABLE_WRITE_MASK  = 8'hbf;
    localparam logic [7:0] PRIORITY_MASK      = 8'h3f;
    localparam logic [7:0] SOURCE_ENABLE_RST  = 8'h00;
    localparam logic [7:0] PRIORITY_LOW_RST   = 8'h00;
    localparam logic [7:0] PRIORITY_HIGH_RST  = 8'h00;
    localparam logic [7:0] READ_UNMAPPED      = 8'h00;

    // ------------------------------------------------------------
    // Sources, in polling rank and in register bit position
    // ------------------------------------------------------------
    localparam int         NUM_SOURCES        = 6;
    localparam int         NUM_LEVELS         = 4;
    localparam logic [2:0] SRC_EXT0           = 3'h0;
    localparam logic [2:0] SRC_TIMER0         = 3'h1;
    localparam logic [2:0] SRC_EXT1           = 3'h2;
    localparam logic [2:0] SRC_TIMER1         = 3'h3;
    localparam logic [2:0] SRC_SERIAL         = 3'h4;
    localparam logic [2:0] SRC_TIMER2         = 3'h5;
    localparam logic [5:0][7:0] VECTORS =
        {8'h2b, 8'h23, 8'h1b, 8'h13, 8'h0b, 8'h03};

    // ------------------------------------------------------------
    // Arbiter state
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_POLL   = 2'b00,
        ST_OFFER  = 2'b01,
        ST_SETTLE = 2'b11
    } arb_state_type;

    typedef struct packed
    {
        arb_state_type state;
        logic [2:0]    offer_src;
        logic [1:0]    offer_level;
        logic [7:0]    vector;
        logic [3:0]    in_service;
        logic [1:0]    ext_sync1;
        logic [1:0]    ext_sync2;
        logic [1:0]    ext_prev;
        logic [1:0]    ext_flag;
        logic          t0_clear;
        logic          t1_clear;
    } arb_regs_type;

    localparam arb_regs_type ARB_RESET = '{
        state:       ST_POLL,
        offer_src:   3'h0,
        offer_level: 2'h0,
        vector:      8'h00,
        in_service:  4'h0,
        ext_sync1:   2'h3,
        ext_sync2:   2'h3,
        ext_prev:    2'h3,
        ext_flag:    2'h0,
        t0_clear:    1'b0,
        t1_clear:    1'b0
    };

    typedef struct packed
    {
        logic [7:0] enable;
        logic [7:0] low;
        logic [7:0] high;
        logic [7:0] rdata;
    } sfr_regs_type;

    localparam sfr_regs_type SFR_RESET = '{
        enable: SOURCE_ENABLE_RST,
        low:    PRIORITY_LOW_RST,
        high:   PRIORITY_HIGH_RST,
        rdata:  READ_UNMAPPED
    };

endpackage

// [rtl/priority_register_file.sv]
`timescale 1ns/1ps
`default_nettype none

module priority_register_file
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    output logic      [7:0] sfr_rdata,
    output logic      [7:0] source_enable_reg,
    output logic      [7:0] priority_low_select,
    output logic      [7:0] priority_high_select
);

    four_level_irq_pkg::sfr_regs_type r;
    four_level_irq_pkg::sfr_regs_type next_r;

    // ------------------------------------------------------------
    // Write decode and registered read
    // ------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        if (sfr_wr && sfr_addr == four_level_irq_pkg::ADDR_SOURCE_ENABLE)
        begin
            next_r.enable = sfr_wdata & four_level_irq_pkg::ENABLE_WRITE_MASK;
        end
        // Top two bits unimplemented, read as zero
        if (sfr_wr && sfr_addr == four_level_irq_pkg::ADDR_PRIORITY_LOW)
        begin
            next_r.low = sfr_wdata & four_level_irq_pkg::PRIORITY_MASK;
        end
        if (sfr_wr && sfr_addr == four_level_irq_pkg::ADDR_PRIORITY_HIGH)
        begin
            next_r.high = sfr_wdata & four_level_irq_pkg::PRIORITY_MASK;
        end
        case (sfr_addr)
            four_level_irq_pkg::ADDR_SOURCE_ENABLE: next_r.rdata = r.enable;
            four_level_irq_pkg::ADDR_PRIORITY_LOW:  next_r.rdata = r.low;
            four_level_irq_pkg::ADDR_PRIORITY_HIGH: next_r.rdata = r.high;
            default: next_r.rdata = four_level_irq_pkg::READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            r <= four_level_irq_pkg::SFR_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign sfr_rdata            = r.rdata;
    assign source_enable_reg    = r.enable;
    assign priority_low_select  = r.low;
    assign priority_high_select = r.high;

endmodule

`default_nettype wire

// [rtl/request_ranker.sv]
`timescale 1ns/1ps
`default_nettype none

module request_ranker
(
    input  wire logic [5:0] pending,
    input  wire logic [5:0] high_bits,
    input  wire logic [5:0] low_bits,
    output logic            found,
    output logic      [2:0] source,
    output logic      [1:0] level
);

    logic [5:0][1:0] src_level;

    // ------------------------------------------------------------
    // Level per source
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 6; g++)
        begin : g_level
            assign src_level[g] = {high_bits[g], low_bits[g]};
        end
    endgenerate

    // ------------------------------------------------------------
    // Highest level wins, then lowest polling rank
    // ------------------------------------------------------------
    always_comb
    begin
        found  = 1'b0;
        source = 3'h0;
        level  = 2'h0;
        // Later hits overwrite earlier ones, so the loop order is the rank
        for (int lv = 0; lv < four_level_irq_pkg::NUM_LEVELS; lv++)
        begin
            for (int s = four_level_irq_pkg::NUM_SOURCES - 1; s >= 0; s--)
            begin
                if (pending[s] && src_level[s] == 2'(lv))
                begin
                    found  = 1'b1;
                    source = 3'(s);
                    level  = 2'(lv);
                end
            end
        end
    end

endmodule

`default_nettype wire
